// ==== src/flash_seq_pkg.sv ====
// Shared constants for the flash command sequencer and its host controller.
// Assumes both ends share one system clock and a mode-0 serial link.
`default_nettype none
package flash_seq_pkg;
  // Command codes
  localparam logic [7:0] CMD_BLOCK_LOCK_SET        = 8'h36;
  localparam logic [7:0] CMD_BLOCK_LOCK_SET_WIDE   = 8'he1;
  localparam logic [7:0] CMD_BLOCK_LOCK_CLEAR      = 8'h39;
  localparam logic [7:0] CMD_BLOCK_LOCK_CLEAR_WIDE = 8'he2;
  localparam logic [7:0] CMD_QUAD_OUTPUT_READ      = 8'h6b;
  localparam logic [7:0] CMD_QUAD_OUTPUT_READ_WIDE = 8'h6c;
  localparam logic [7:0] CMD_QUAD_IO_READ          = 8'heb;
  localparam logic [7:0] CMD_QUAD_IO_READ_WIDE     = 8'hec;
  localparam logic [7:0] CMD_DOUBLE_RATE_QUAD_READ = 8'hed;
  localparam logic [7:0] CMD_MODE_BIT_RESET        = 8'hff;
  localparam logic [7:0] CMD_SECURE_REGION_PROGRAM = 8'h42;
  localparam logic [7:0] CMD_SECURE_REGION_READ    = 8'h48;
  localparam logic [7:0] CMD_SECURE_REGION_ERASE   = 8'h44;
  localparam logic [7:0] CMD_SUSPEND_RESUME        = 8'h7a;
  localparam logic [7:0] CMD_WRITE_ENABLE          = 8'h06;
  localparam logic [7:0] CMD_STATUS_CONFIG_WRITE   = 8'h01;
  localparam logic [7:0] CMD_ANY_REGISTER_WRITE    = 8'h71;
  localparam logic [7:0] CMD_POINTER_REGION_PROG   = 8'hfb;
  localparam logic [7:0] CMD_PAGE_PROGRAM          = 8'h02;
  localparam logic [7:0] CMD_QUAD_PAGE_PROGRAM     = 8'h32;
  localparam logic [7:0] CMD_PROGRAM_SUSPEND       = 8'h75;
  // Address fields
  localparam int ADDR_W        = 24;
  localparam int REGION_LO     = 8;
  localparam int REGION_HI     = 15;
  localparam int ZERO_FROM_BIT = 10;
  localparam logic [7:0] REGION_MAX = 8'h03;
  localparam logic [1:0] REGION_2   = 2'h2;
  // Status bit positions
  localparam int ST_WIP      = 0;
  localparam int ST_WEL      = 1;
  localparam int ST_PSUS     = 2;
  localparam int ST_ESUS     = 3;
  localparam int ST_E_ERR    = 4;
  localparam int STATUS_W    = 5;
  // Erase time in system cycles (10 MHz clock)
  localparam int ERASE_TIME_US  = 100;
  localparam int CLK_MHZ        = 10;
  localparam int ERASE_CYCLES   = ERASE_TIME_US * CLK_MHZ;
  localparam int CNT_W          = 16;
  // Host serial clock divider, half period in system cycles
  localparam int SCK_HALF       = 4;
  localparam int DIV_W          = 4;
  // Host register offsets
  localparam logic [1:0] HOST_OFS_CTRL   = 2'h0;
  localparam logic [1:0] HOST_OFS_ADDR   = 2'h1;
  localparam logic [1:0] HOST_OFS_STATUS = 2'h2;
  localparam int HCTRL_QUAD  = 8;
  localparam int HCTRL_START = 9;
  localparam int HCTRL_ADDR  = 10;
endpackage
`default_nettype wire

// ==== src/flash_link_if.sv ====
// Serial link between the host controller and the flash sequencer.
// Resolves the four data lines from the output enables; a line driven by neither side reads high.
`default_nettype none
interface flash_link_if;
  logic       sck;
  logic       cs_n;
  logic [3:0] io_host;
  logic [3:0] io_host_oe;
  logic [3:0] io_dev;
  logic [3:0] io_dev_oe;
  logic [3:0] io;
  assign io = (io_host & io_host_oe) | (io_dev & io_dev_oe) | ~(io_host_oe | io_dev_oe);
  modport host (output sck, output cs_n, output io_host, output io_host_oe, input io);
  modport dev  (input sck, input cs_n, output io_dev, output io_dev_oe, input io);
endinterface
`default_nettype wire

// ==== src/flash_seq_dev.sv ====
// Flash-side command decoder: suspend gating, resume and security region erase.
// Assumes the host keeps a mode-0 serial clock; sampled by clk_sys_i.
// Operation
// - Block lock commands accepted during either suspend
// - Quad array reads accepted during either suspend
// - Mode bit reset accepted during either suspend
// - Region program only during erase suspend
// - Region read accepted during either suspend
// - Host sets quad enable before suspendable work
// - All other commands refused while suspended
// - Reads of suspended sector give undefined data
// - Program in erase suspend returns there
// - Resume sets busy and continues operation
// - Resume without suspension is ignored
// - Host spaces resume and next suspend
// - Suspend flags distinguish suspension from completion
// - Quad mode sends instruction four bits per clock
// - Region chosen by address bits 15..8
// - Region erase separate; high address bits zero
// - Region erase requires write enable latch
// - Busy until done; failure sets erase error
// - Locked region erase fails with error
// - Protection lock zero protects regions two, three
// - Password mode protects regions two, three
// - Region erase uses sector erase sequence
// - Program ignored while a program is suspended
`default_nettype none
module flash_seq_dev
  import flash_seq_pkg::*;
(
  // Clock and reset
  input  wire logic                clk_sys_i,
  input  wire logic                nrst_i,
  // Link
  flash_link_if.dev                link,
  // Configuration and protection state
  input  wire logic                quad_peripheral_mode_i,
  input  wire logic [3:0]          region_lock_i,
  input  wire logic                protection_nv_lock_bit_i,
  input  wire logic                password_mode_lock_i,
  input  wire logic                password_ok_i,
  // Suspend and completion events from the array engine
  input  wire logic                program_suspend_i,
  input  wire logic                erase_suspend_i,
  input  wire logic                program_done_i,
  // Status and decoded command
  output logic [STATUS_W-1:0]      status_o,
  output logic                     cmd_valid_o,
  output logic [7:0]               cmd_o,
  output logic                     cmd_refused_o,
  output logic                     read_undefined_o,
  output logic                     region_erase_busy_o
);
  logic [2:0] sck_sync_reg, cs_sync_reg;
  logic [3:0] io_sync1_reg, io_sync2_reg;
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      sck_sync_reg <= 3'h0;
      cs_sync_reg  <= 3'h7;
      io_sync1_reg <= 4'h0;
      io_sync2_reg <= 4'h0;
    end else begin
      sck_sync_reg <= {sck_sync_reg[1:0], link.sck};
      cs_sync_reg  <= {cs_sync_reg[1:0], link.cs_n};
      io_sync1_reg <= link.io;
      io_sync2_reg <= io_sync1_reg;
    end
  end
  // Edge detection looks only at the second and third stages
  wire sck_rise = sck_sync_reg[1] & ~sck_sync_reg[2];
  wire cs_low   = ~cs_sync_reg[1];
  wire cs_rise  = cs_sync_reg[1] & ~cs_sync_reg[2];
  wire step4    = quad_peripheral_mode_i;

  assign link.io_dev    = 4'h0;
  assign link.io_dev_oe = 4'h0;

  // Frame shifter: instruction then 24-bit address
  logic [31:0] shift_reg;
  logic [5:0]  bits_reg;
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i || !cs_low) begin
      shift_reg <= 32'h0;
      bits_reg  <= 6'h0;
    end else if (sck_rise && bits_reg < 6'd32) begin
      if (step4) begin
        shift_reg <= {shift_reg[27:0], io_sync2_reg};
        bits_reg  <= bits_reg + 6'd4;
      end else begin
        shift_reg <= {shift_reg[30:0], io_sync2_reg[0]};
        bits_reg  <= bits_reg + 6'd1;
      end
    end
  end
  wire [7:0]        frame_cmd  = (bits_reg >= 6'd32) ? shift_reg[31:24] : shift_reg[7:0];
  wire [ADDR_W-1:0] frame_addr = shift_reg[ADDR_W-1:0];
  wire              had_cmd    = bits_reg >= 6'd8;

  logic wip_reg, wel_reg, psus_reg, esus_reg, eerr_reg;
  logic erase_run_reg;
  logic [CNT_W-1:0] erase_cnt_reg;
  wire suspended = psus_reg | esus_reg;

  // Suspend filter
  logic allowed;
  always_comb begin
    allowed = 1'b0;
    unique case (frame_cmd)
      CMD_BLOCK_LOCK_SET, CMD_BLOCK_LOCK_SET_WIDE,
      CMD_BLOCK_LOCK_CLEAR, CMD_BLOCK_LOCK_CLEAR_WIDE: allowed = 1'b1;
      CMD_QUAD_OUTPUT_READ, CMD_QUAD_OUTPUT_READ_WIDE, CMD_QUAD_IO_READ,
      CMD_QUAD_IO_READ_WIDE, CMD_DOUBLE_RATE_QUAD_READ: allowed = 1'b1;
      CMD_MODE_BIT_RESET:        allowed = 1'b1;
      CMD_SECURE_REGION_PROGRAM: allowed = esus_reg & ~psus_reg;
      CMD_SECURE_REGION_READ:    allowed = 1'b1;
      CMD_SUSPEND_RESUME:        allowed = 1'b1;
      CMD_PAGE_PROGRAM, CMD_QUAD_PAGE_PROGRAM: allowed = esus_reg & ~psus_reg;
      default:                   allowed = 1'b0;
    endcase
  end
  wire refused = suspended & ~allowed;

  wire frame_end = cs_rise & had_cmd;
  wire take      = frame_end & ~refused & ~erase_run_reg;

  // Region erase checks
  wire [7:0] region_byte = frame_addr[REGION_HI:REGION_LO];
  wire [1:0] region      = region_byte[1:0];
  wire addr_ok   = (frame_addr[ADDR_W-1:ZERO_FROM_BIT] == '0) && (region_byte <= REGION_MAX);
  wire hi_region = region >= REGION_2;
  wire protect   = region_lock_i[region]
                 | (hi_region & ~protection_nv_lock_bit_i)
                 | (hi_region & password_mode_lock_i & ~password_ok_i);
  // Sector-erase shape: instruction plus full address, ended by chip-select rise
  wire is_erase = take && frame_cmd == CMD_SECURE_REGION_ERASE && bits_reg == 6'd32 && !suspended;
  wire erase_go = is_erase & wel_reg;
  wire erase_ok = addr_ok & ~protect;
  wire is_resume = take && frame_cmd == CMD_SUSPEND_RESUME && bits_reg == 6'd8;

  // Region erase engine
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      erase_run_reg <= 1'b0;
      erase_cnt_reg <= '0;
    end else if (erase_go && erase_ok) begin
      erase_run_reg <= 1'b1;
      erase_cnt_reg <= CNT_W'(ERASE_CYCLES);
    end else if (erase_run_reg) begin
      erase_cnt_reg <= erase_cnt_reg - 1'b1;
      if (erase_cnt_reg == 1) erase_run_reg <= 1'b0;
    end
  end
  wire erase_done = erase_run_reg && erase_cnt_reg == 1;

  // Write enable latch
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) wel_reg <= 1'b0;
    else if (take && frame_cmd == CMD_WRITE_ENABLE && !suspended) wel_reg <= 1'b1;
    else if (erase_go) wel_reg <= 1'b0;
  end

  // Write in progress
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) wip_reg <= 1'b0;
    else if (is_resume && suspended) wip_reg <= 1'b1;
    else if (erase_go && erase_ok) wip_reg <= 1'b1;
    else if (erase_done || program_done_i || program_suspend_i || erase_suspend_i) wip_reg <= 1'b0;
    else if (erase_go) wip_reg <= 1'b0;
  end

  // Suspend flags; a resume clears program suspend first, then erase suspend
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      psus_reg <= 1'b0;
      esus_reg <= 1'b0;
    end else begin
      if (program_suspend_i) psus_reg <= 1'b1;
      else if (is_resume && psus_reg) psus_reg <= 1'b0;
      if (erase_suspend_i) esus_reg <= 1'b1;
      else if (is_resume && esus_reg && !psus_reg) esus_reg <= 1'b0;
    end
  end

  // Erase error is sticky until reset
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) eerr_reg <= 1'b0;
    else if (erase_go && !erase_ok) eerr_reg <= 1'b1;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      cmd_valid_o      <= 1'b0;
      cmd_o            <= 8'h0;
      cmd_refused_o    <= 1'b0;
      read_undefined_o <= 1'b0;
    end else begin
      cmd_valid_o   <= take;
      cmd_refused_o <= frame_end & refused;
      if (take) cmd_o <= frame_cmd;
      // Every command other than region read accepted while suspended is flagged so the array path may drive junk
      if (take) read_undefined_o <= suspended && frame_cmd != CMD_SECURE_REGION_READ && allowed;
    end
  end

  assign status_o = {eerr_reg, esus_reg, psus_reg, wel_reg, wip_reg};
  assign region_erase_busy_o = erase_run_reg;
endmodule // flash_seq_dev
`default_nettype wire

// ==== src/flash_host_ctrl.sv ====
// Host controller: sends one instruction with optional 24-bit address.
// Assumes software follows the order of write enable and quad setup.
`default_nettype none
module flash_host_ctrl
  import flash_seq_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  // Register port
  input  wire logic [1:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [31:0]      rdata_o,
  // Link
  flash_link_if.host       link
);
  typedef enum logic [1:0] {H_IDLE = 2'b00, H_LOW = 2'b01, H_HIGH = 2'b10, H_END = 2'b11} hstate_t;
  hstate_t          state_reg;
  logic [31:0]      sh_reg;
  logic [5:0]       left_reg;
  logic [23:0]      addr_reg;
  logic             quad_reg, sck_reg, cs_n_reg;
  logic [DIV_W-1:0] div_reg;
  wire tick = div_reg == DIV_W'(SCK_HALF - 1);
  wire start = wr_i && addr_i == HOST_OFS_CTRL && wdata_i[HCTRL_START] && state_reg == H_IDLE;

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) addr_reg <= 24'h0;
    else if (wr_i && addr_i == HOST_OFS_ADDR) addr_reg <= wdata_i[23:0];
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i || state_reg == H_IDLE) div_reg <= '0;
    else div_reg <= tick ? '0 : div_reg + 1'b1;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      state_reg <= H_IDLE;
      sh_reg    <= 32'h0;
      left_reg  <= 6'h0;
      quad_reg  <= 1'b0;
      sck_reg   <= 1'b0;
      cs_n_reg  <= 1'b1;
    end else begin
      unique case (state_reg)
        H_IDLE: if (start) begin
          sh_reg   <= {wdata_i[7:0], addr_reg};
          left_reg <= wdata_i[HCTRL_ADDR] ? 6'd32 : 6'd8;
          quad_reg <= wdata_i[HCTRL_QUAD];
          cs_n_reg <= 1'b0;
          state_reg <= H_LOW;
        end
        H_LOW: if (tick) begin
          sck_reg   <= 1'b1;
          state_reg <= H_HIGH;
        end
        H_HIGH: if (tick) begin
          sck_reg <= 1'b0;
          if (quad_reg) begin
            sh_reg   <= {sh_reg[27:0], 4'h0};
            left_reg <= left_reg - 6'd4;
          end else begin
            sh_reg   <= {sh_reg[30:0], 1'b0};
            left_reg <= left_reg - 6'd1;
          end
          state_reg <= ((quad_reg && left_reg == 6'd4) || (!quad_reg && left_reg == 6'd1)) ? H_END : H_LOW;
        end
        H_END: if (tick) begin
          cs_n_reg  <= 1'b1;
          state_reg <= H_IDLE;
        end
      endcase
    end
  end

  assign link.sck        = sck_reg;
  assign link.cs_n       = cs_n_reg;
  assign link.io_host    = quad_reg ? sh_reg[31:28] : {3'h0, sh_reg[31]};
  assign link.io_host_oe = (state_reg == H_LOW || state_reg == H_HIGH) ? (quad_reg ? 4'hf : 4'h1) : 4'h0;

  // Quad enable and resume spacing are software duties
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) rdata_o <= 32'h0;
    else if (rd_i && addr_i == HOST_OFS_STATUS) rdata_o <= {31'h0, state_reg != H_IDLE};
    else if (rd_i && addr_i == HOST_OFS_ADDR) rdata_o <= {8'h0, addr_reg};
    else rdata_o <= 32'h0;
  end
endmodule // flash_host_ctrl
`default_nettype wire

// ==== tb/flash_link_checker.sv ====
// Checker for the flash link: watches the shared interface and the sequencer outputs.
// Assumes one system clock with a synchronous active-low reset.
`default_nettype none
module flash_link_checker
  import flash_seq_pkg::*;
(
  // Clock and reset
  input  wire logic                clk_sys_i,
  input  wire logic                nrst_i,
  // Link
  input  wire logic                sck,
  input  wire logic                cs_n,
  input  wire logic [3:0]          io_dev_oe,
  // Sequencer outputs
  input  wire logic [STATUS_W-1:0] status_o,
  input  wire logic                cmd_valid_o,
  input  wire logic [7:0]          cmd_o,
  input  wire logic                cmd_refused_o,
  input  wire logic                region_erase_busy_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  // Status one cycle back, cleared by reset so a mid-run reset never looks like a change
  logic [STATUS_W-1:0] st_q;
  logic                sus_q;
  // Erase is too long to unroll as a delay range, so a counter measures it
  logic [CNT_W-1:0]    busy_cnt_reg;
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) busy_cnt_reg <= '0;
    else busy_cnt_reg <= region_erase_busy_o ? busy_cnt_reg + 1'b1 : '0;
  end
  always_ff @(posedge clk_sys_i) begin
    st_q  <= nrst_i ? status_o : '0;
    sus_q <= nrst_i & (status_o[ST_PSUS] | status_o[ST_ESUS]);
  end
  dev_quiet_a: assert property (io_dev_oe == 4'h0)
    else $error("sequencer drives the data lines");
  sck_idle_a: assert property (cs_n |-> !sck)
    else $error("serial clock high outside a frame");
  one_answer_a: assert property (!(cmd_valid_o && cmd_refused_o))
    else $error("command accepted and refused at once");
  allowed_set_a: assert property (cmd_valid_o && sus_q |-> cmd_o inside {8'h36, 8'he1, 8'h39, 8'he2,
    8'h6b, 8'h6c, 8'heb, 8'hec, 8'hed, 8'hff, 8'h42, 8'h48, 8'h7a, 8'h02, 8'h32})
    else $error("command outside the suspend set accepted");
  prog_sus_filter_a: assert property (cmd_valid_o && st_q[ST_PSUS] |-> !(cmd_o inside {8'h42, 8'h02, 8'h32}))
    else $error("program accepted during program suspend");
  resume_busy_a: assert property (cmd_valid_o && cmd_o == 8'h7a && sus_q |-> status_o[ST_WIP])
    else $error("resume did not raise busy");
  resume_idle_a: assert property (cmd_valid_o && cmd_o == 8'h7a && !sus_q |-> status_o == st_q)
    else $error("idle resume changed status");
  erase_needs_wel_a: assert property ($rose(region_erase_busy_o) |-> st_q[ST_WEL])
    else $error("region erase started without write enable");
  erase_busy_wip_a: assert property (region_erase_busy_o |-> status_o[ST_WIP])
    else $error("busy flag low during region erase");
  erase_time_a: assert property ($fell(region_erase_busy_o) |-> busy_cnt_reg == CNT_W'(ERASE_CYCLES))
    else $error("region erase length wrong");
  erase_bound_a: assert property (region_erase_busy_o |-> busy_cnt_reg < CNT_W'(ERASE_CYCLES))
    else $error("region erase runs too long");
  err_sticky_a: assert property (st_q[ST_E_ERR] |-> status_o[ST_E_ERR])
    else $error("erase error flag dropped");
endmodule // flash_link_checker
`default_nettype wire

// ==== tb/tb_top.sv ====
// Bench joining the host controller and the flash sequencer over the link.
// Assumes the sequencer answers within a few cycles of the frame ending.
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, a, b); end end
module tb_top;
  import flash_seq_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk_sys_i = 1'b0;
  logic              nrst_i    = 1'b0;
  logic [1:0]        addr_i    = '0;
  logic [31:0]       wdata_i   = '0;
  logic              wr_i      = 1'b0;
  logic              rd_i      = 1'b0;
  logic [31:0]       rdata_o;
  logic              quad_mode = 1'b0;
  logic [3:0]        region_lock = '0;
  logic              nv_lock   = 1'b1;
  logic              pw_lock   = 1'b0;
  logic              pw_ok     = 1'b0;
  logic              prog_sus  = 1'b0;
  logic              erase_sus = 1'b0;
  logic              prog_done = 1'b0;
  logic [STATUS_W-1:0] status;
  logic              cmd_valid;
  logic [7:0]        cmd_code;
  logic              cmd_refused;
  logic              rd_undef;
  logic              erase_busy;
  int                fail_count = 0;
  int                checks = 0;
  logic [8:0]        notes[$];
  logic [8:0]        note;
  logic [7:0]        s_op;
  logic              s_q, s_ae, live = 1'b0;
  logic [23:0]       s_addr;
  logic [31:0]       wsh;
  int                wn, n, c, r, k;
  logic [7:0]        b;
  logic [31:0]       rdw;
  logic [7:0]        ok_op[11]  = '{8'he1, 8'h39, 8'he2, 8'h6b, 8'h6c, 8'heb, 8'hec, 8'hed, 8'hff, 8'h48, 8'h36};
  logic [7:0]        bad_op[6]  = '{8'h01, 8'h71, 8'hfb, 8'h06, 8'h44, 8'h20};
  flash_link_if link ();
  flash_host_ctrl i_flash_host_ctrl (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .link(link.host));
  flash_seq_dev i_flash_seq_dev (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .link(link.dev),
    .quad_peripheral_mode_i(quad_mode), .region_lock_i(region_lock), .protection_nv_lock_bit_i(nv_lock),
    .password_mode_lock_i(pw_lock), .password_ok_i(pw_ok), .program_suspend_i(prog_sus),
    .erase_suspend_i(erase_sus), .program_done_i(prog_done), .status_o(status), .cmd_valid_o(cmd_valid),
    .cmd_o(cmd_code), .cmd_refused_o(cmd_refused), .read_undefined_o(rd_undef), .region_erase_busy_o(erase_busy));
  flash_link_checker i_flash_link_checker (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .sck(link.sck),
    .cs_n(link.cs_n), .io_dev_oe(link.io_dev_oe), .status_o(status), .cmd_valid_o(cmd_valid), .cmd_o(cmd_code),
    .cmd_refused_o(cmd_refused), .region_erase_busy_o(erase_busy));
  initial begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic expire();
    fail_count++;
    $display("unexpected at %0t: wait ran out", $time);
    end_of_test();
  endtask
  task automatic reg_wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic reg_rd(input logic [1:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  // Note -1 means the sequencer may stay silent, so nothing is queued
  task automatic send(input logic [7:0] op, input logic q, input logic ae, input logic [23:0] a, input int nt);
    logic [31:0] d;
    int i;
    s_op = op;
    s_q = q;
    s_ae = ae;
    s_addr = a;
    live = 1'b1;
    if (nt >= 0) notes.push_back({nt[0], op});
    reg_wr(HOST_OFS_ADDR, {8'h00, a});
    reg_wr(HOST_OFS_CTRL, {21'h0, ae, 1'b1, q, op});
    d = 32'h1;
    for (i = 0; i < 300 && d[0] !== 1'b0; i++) reg_rd(HOST_OFS_STATUS, d);
    for (i = 0; i < 20 && notes.size() > 0; i++) @(posedge clk_sys_i);
    if (d[0] !== 1'b0 || notes.size() > 0) expire();
    repeat (6) @(posedge clk_sys_i);
  endtask
  task automatic pulse(input int e);
    @(posedge clk_sys_i);
    if (e == 0) prog_sus <= 1'b1;
    else if (e == 1) erase_sus <= 1'b1;
    else prog_done <= 1'b1;
    @(posedge clk_sys_i);
    {prog_sus, erase_sus, prog_done} <= 3'b000;
    repeat (2) @(posedge clk_sys_i);
  endtask
  // Answer watcher: a refusal leaves the last accepted code in place, so only acceptances compare it
  always @(posedge clk_sys_i) begin
    if ((cmd_valid === 1'b1 || cmd_refused === 1'b1) && notes.size() > 0) begin
      note = notes.pop_front();
      `CHK(cmd_refused, note[8])
      if (note[8] === 1'b0) `CHK(cmd_code, note[7:0])
    end
  end
  // Wire watcher: bits are taken on rising serial clock, most significant first
  always @(negedge link.cs_n) begin
    wsh = '0;
    wn = 0;
  end
  always @(posedge link.sck) if (link.cs_n === 1'b0) begin
    wsh = s_q ? {wsh[27:0], link.io} : {wsh[30:0], link.io[0]};
    wn += s_q ? 4 : 1;
  end
  always @(posedge link.cs_n) if (live) begin
    `CHK(wn, s_ae ? 32 : 8)
    `CHK(wsh, s_ae ? {s_op, s_addr} : {24'h0, s_op})
  end
  initial begin
    void'($urandom(49825));
    repeat (2) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    send(8'h7a, 1'b0, 1'b0, 24'h0, 0);
    `CHK(status, 5'h00)
    send(8'h44, 1'b0, 1'b1, 24'h000100, -1);
    `CHK(erase_busy, 1'b0)
    send(8'h06, 1'b0, 1'b0, 24'h0, 0);
    `CHK(status, 5'h02)
    b = 8'($urandom);
    send(8'h44, 1'b0, 1'b1, {16'h0001, b}, 0);
    `CHK(status[ST_WIP], 1'b1)
    reg_rd(HOST_OFS_ADDR, rdw);
    `CHK(rdw, {8'h00, 16'h0001, b})
    send(8'h48, 1'b0, 1'b0, 24'h0, -1);
    for (n = 0; n < 1200 && erase_busy !== 1'b0; n++) @(posedge clk_sys_i);
    if (erase_busy !== 1'b0) expire();
    `CHK(status[ST_WIP] | status[ST_E_ERR], 1'b0)
    $display("test erase done");
    // One protection or address-range fault picked at random, since the error flag cannot be cleared
    c = $urandom % 4;
    r = (c == 0) ? $urandom % 4 : 2 + $urandom % 2;
    @(posedge clk_sys_i);
    region_lock[r] <= (c == 0);
    nv_lock <= (c != 1);
    pw_lock <= (c == 2);
    send(8'h06, 1'b0, 1'b0, 24'h0, 0);
    send(8'h44, 1'b0, 1'b1, {8'h00, 8'(r) | ((c == 3) ? 8'h04 : 8'h00), 8'h10}, -1);
    `CHK(status, 5'h10)
    region_lock <= '0;
    nv_lock <= 1'b1;
    pw_lock <= 1'b0;
    $display("test fault %0d done", c);
    pulse(1);
    for (k = 0; k < 2; k++) begin
      `CHK(status, (k == 1) ? 5'h1c : 5'h18)
      foreach (ok_op[i]) send(ok_op[i], 1'b0, 1'b0, 24'h0, 0);
      foreach (bad_op[i]) send(bad_op[i], 1'b0, 1'b0, 24'h0, 1);
      send(8'h42, 1'b0, 1'b0, 24'h0, k);
      send(8'h02, 1'b0, 1'b0, 24'h0, k);
      send(8'heb, 1'b0, 1'b0, 24'h0, 0);
      `CHK(rd_undef, 1'b1)
      if (k == 0) pulse(0);
    end
    $display("test suspend filter done");
    @(posedge clk_sys_i);
    quad_mode <= 1'b1;
    send(8'h7a, 1'b1, 1'b0, 24'h0, 0);
    `CHK(status, 5'h19)
    pulse(2);
    `CHK(status, 5'h18)
    send(8'h7a, 1'b1, 1'b0, 24'h0, 0);
    `CHK(status, 5'h11)
    send(8'heb, 1'b1, 1'b0, 24'h0, 0);
    `CHK(rd_undef, 1'b0)
    $display("test resume done");
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
